/* hdl/bts_pkg.sv */
package bts_pkg;

	// ****************************************************
	// Register map (byte addresses)
	// ****************************************************
	localparam logic [7:0] BTS_OFS_INSTR = 8'h00;
	localparam logic [7:0] BTS_OFS_IADDR = 8'h04;
	localparam logic [7:0] BTS_OFS_STATUS = 8'h08;
	localparam logic [7:0] BTS_OFS_CUR_SW = 8'h0C;
	localparam logic [7:0] BTS_OFS_SAVED_SW = 8'h10;
	localparam logic [7:0] BTS_OFS_CYCLES = 8'h14;
	localparam int BTS_RF_WIN_BIT = 7;
	localparam int BTS_RF_BANK_BIT = 6;

	// ****************************************************
	// Instruction word fields
	// ****************************************************
	localparam int BTS_BIT_PRE = 24;
	localparam int BTS_BIT_UP = 23;
	localparam int BTS_BIT_USER = 22;
	localparam int BTS_BIT_WB = 21;
	localparam int BTS_BIT_LOAD = 20;
	localparam int BTS_BASE_MSB = 19;
	localparam int BTS_BASE_LSB = 16;
	localparam int BTS_NREGS = 16;

	// ****************************************************
	// Status bits and constants
	// ****************************************************
	localparam int BTS_ST_BUSY = 0;
	localparam int BTS_ST_ABORT = 1;
	localparam int BTS_ST_PCLOAD = 2;
	localparam logic [3:0] BTS_PC_IDX = 4'hF;
	localparam logic [31:0] BTS_PC_STORE_OFS = 32'h0000000C;
	localparam logic [31:0] BTS_WORD_BYTES = 32'h00000004;
	localparam logic BTS_BANK_CUR = 1'b0;
	localparam logic BTS_BANK_USER = 1'b1;

	typedef enum logic [1:0] {BTS_CYC_NONE, BTS_CYC_N, BTS_CYC_S, BTS_CYC_I} bts_cyc_e;

	typedef enum logic [2:0] {
		BTS_IDLE, BTS_LDBASE, BTS_PREF, BTS_XFER, BTS_INT, BTS_PCN, BTS_PCS, BTS_END
	} bts_state_e;

	typedef struct packed {
		logic pre;
		logic up;
		logic user;
		logic wb;
		logic load;
		logic [3:0] base;
		logic [15:0] list;
	} bts_instr_s;

	typedef struct packed {
		logic active;
		logic write;
		bts_cyc_e ctype;
		logic [31:0] addr;
		logic [31:0] wdata;
	} bts_mem_req_s;

	function automatic bts_instr_s bts_decode(input logic [31:0] w);
		bts_instr_s d;
		d.pre = w[BTS_BIT_PRE];
		d.up = w[BTS_BIT_UP];
		d.user = w[BTS_BIT_USER];
		d.wb = w[BTS_BIT_WB];
		d.load = w[BTS_BIT_LOAD];
		d.base = w[BTS_BASE_MSB:BTS_BASE_LSB];
		d.list = w[BTS_NREGS-1:0];
		return d;
	endfunction

endpackage

/* hdl/bts_regfile.sv */
`timescale 1ns/1ps
module bts_regfile (
	input wire logic hclk, // Clock
	input wire logic hresetn, // Async reset, active low
	input wire logic wa_en, // Write port A enable
	input wire logic [4:0] wa_addr, // Write port A index
	input wire logic [31:0] wa_data, // Write port A data
	input wire logic wb_en, // Write port B enable
	input wire logic [4:0] wb_addr, // Write port B index
	input wire logic [31:0] wb_data, // Write port B data
	input wire logic [4:0] rd_addr, // Read index
	output logic [31:0] rd_data // Registered read data
);
	logic [31:0] mem_r [0:31];

	// ****************************************************
	// Two write ports, port A wins on a clash
	// ****************************************************
	genvar gi;
	generate
		for (gi = 0; gi < 32; gi++) begin : g_word
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					mem_r[gi] <= 32'h00000000;
				end else if (wa_en && wa_addr == 5'(gi)) begin
					mem_r[gi] <= wa_data;
				end else if (wb_en && wb_addr == 5'(gi)) begin
					mem_r[gi] <= wb_data;
				end
			end
		end
	endgenerate

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_data <= 32'h00000000;
		end else begin
			rd_data <= mem_r[rd_addr];
		end
	end
endmodule

/* hdl/bts_pick.sv */
`timescale 1ns/1ps
module bts_pick (
	input wire logic [15:0] mask, // Remaining register mask
	output logic [3:0] low_idx, // Lowest set bit
	output logic [15:0] low_hot, // Lowest set bit, one-hot
	output logic [4:0] count // Number of set bits
);
	import bts_pkg::*;
	// ****************************************************
	// Lowest-first priority pick and population count
	// ****************************************************
	always_comb begin
		low_idx = 4'h0;
		count = 5'h00;
		for (int i = BTS_NREGS - 1; i >= 0; i--) begin
			if (mask[i]) begin
				low_idx = 4'(i);
			end
		end
		for (int i = 0; i < BTS_NREGS; i++) begin
			count = count + 5'(mask[i]);
		end
	end

	assign low_hot = mask & (~mask + 16'h0001);
endmodule

/* hdl/bts_top.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Bit i of the 16-bit mask selects register i for transfer.
// - A stored program counter register reads as instruction address plus 12.
// - Registers move lowest first, so the program counter register goes last.
// - Addresses come from base, pre and up bits; lowest register at lowest address.
// - Without write-back the base keeps its value unless loaded.
// - Low two address bits are ignored internally but still driven out.
// - User-bit load with program counter copies saved into current status word.
// - User-bit store with program counter reads the user bank.
// - User bit without program counter: both directions use the user bank.
// - Write-back ends cycle two; first store starts cycle two.
// - A loaded base replaces the written-back base.
// - Store abort: finish, then trap; only base write-back changes state.
// - Load abort: suppress that load and all later writes, then trap.
// - After a load abort the base is restored to updated or original value.
// - Cycle counts: load nS+1N+1I, with PC (n+1)S+2N+1I, store (n-1)S+2N.
// - Write-back bit requests base update; user bit requests restore or user bank.
// - Pre and up bits give IA, IB, DA, DB modes; load bit picks direction.
module bts_top (
	input wire logic hclk, // Clock, 10 MHz
	input wire logic hresetn, // Async reset, active low
	input wire logic hsel, // Slave select
	input wire logic [31:0] haddr, // Address
	input wire logic [1:0] htrans, // Transfer type
	input wire logic hwrite, // Write
	input wire logic [2:0] hsize, // Transfer size
	input wire logic [31:0] hwdata, // Write data
	input wire logic hready, // Bus ready
	output logic [31:0] hrdata, // Read data
	output logic hreadyout, // Slave ready
	output logic hresp, // Response, always OKAY
	output bts_pkg::bts_mem_req_s mem_req, // Memory transfer request
	input wire logic [31:0] mem_rdata, // Memory read data
	input wire logic mem_abort, // Abort from memory manager
	output logic data_abort_trap // Pulse: take data abort trap
);
	import bts_pkg::*;

	// ****************************************************
	// Bus slave: address and data phase
	// ****************************************************
	logic dp_valid_r, dp_write_r, rd_ok_r;
	logic [7:0] dp_addr_r;
	logic busy;
	wire addr_ok = hsel && hready && htrans[1];
	wire dp_rf = dp_addr_r[BTS_RF_WIN_BIT];
	wire ap_rf_rd = addr_ok && !hwrite && haddr[BTS_RF_WIN_BIT];
	wire dp_stall = dp_valid_r && busy && (dp_write_r || dp_rf);
	wire dp_rd_wait = dp_valid_r && dp_rf && !dp_write_r && !rd_ok_r;
	wire dp_done = dp_valid_r && !dp_stall && !dp_rd_wait;
	wire dp_wr = dp_done && dp_write_r;
	wire [4:0] dp_rf_idx = dp_addr_r[BTS_RF_BANK_BIT:2];
	assign hreadyout = !dp_valid_r || dp_done;
	assign hresp = 1'b0;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_valid_r <= 1'b0;
			dp_write_r <= 1'b0;
			dp_addr_r <= 8'h00;
		end else if (hreadyout) begin
			dp_valid_r <= addr_ok;
			dp_write_r <= hwrite;
			dp_addr_r <= haddr[7:0];
		end
	end

	wire rd_issue_ap = hreadyout && ap_rf_rd && !busy;
	wire rd_issue_dp = dp_rd_wait && !busy;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_ok_r <= 1'b0;
		end else begin
			rd_ok_r <= rd_issue_ap || (rd_issue_dp && !rd_ok_r) || (rd_ok_r && !hreadyout);
		end
	end

	// ****************************************************
	// Control and status registers
	// ****************************************************
	logic [31:0] iaddr_r, cur_sw_r, saved_sw_r, cycles_r, cycles_nxt;
	logic abort_flag_r, pcload_flag_r;
	bts_instr_s ins_r;
	bts_state_e state_r, state_nxt;
	logic abort_r, first_r, wbdone_r;
	logic [31:0] addr_r, orig_base_r, newb_r;
	logic [15:0] rem_r;
	logic [3:0] cur_r;
	wire start = dp_wr && dp_addr_r == BTS_OFS_INSTR;
	wire seq_end = state_r == BTS_END;
	wire pc_step = state_r == BTS_XFER && ins_r.load && cur_r == BTS_PC_IDX;
	wire ab_any = abort_r || mem_abort;
	wire sw_restore = pc_step && ins_r.user && !ab_any;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			iaddr_r <= 32'h00000000;
			cur_sw_r <= 32'h00000000;
			saved_sw_r <= 32'h00000000;
		end else begin
			if (dp_wr && dp_addr_r == BTS_OFS_IADDR) begin
				iaddr_r <= hwdata;
			end
			if (sw_restore) begin
				cur_sw_r <= saved_sw_r;
			end else if (dp_wr && dp_addr_r == BTS_OFS_CUR_SW) begin
				cur_sw_r <= hwdata;
			end
			if (dp_wr && dp_addr_r == BTS_OFS_SAVED_SW) begin
				saved_sw_r <= hwdata;
			end
		end
	end

	// Sticky flags; a set in the clearing cycle wins
	wire clr_st = dp_wr && dp_addr_r == BTS_OFS_STATUS;
	wire set_abort = seq_end && abort_r;
	wire set_pcl = pc_step && !ab_any;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			abort_flag_r <= 1'b0;
			pcload_flag_r <= 1'b0;
		end else begin
			abort_flag_r <= set_abort || (abort_flag_r && !(clr_st && hwdata[BTS_ST_ABORT]));
			pcload_flag_r <= set_pcl || (pcload_flag_r && !(clr_st && hwdata[BTS_ST_PCLOAD]));
		end
	end

	// ****************************************************
	// Register file and lowest-register pick
	// ****************************************************
	logic [31:0] rf_rdata;
	logic [3:0] low_idx;
	logic [15:0] low_hot;
	logic [4:0] list_cnt;

	// User bank unless a load also reloads the program counter register
	wire xbank = ins_r.user && !(ins_r.load && ins_r.list[BTS_PC_IDX]);
	wire seq_rd = state_r == BTS_PREF || state_r == BTS_XFER;
	wire [4:0] seq_raddr = state_r == BTS_LDBASE ? {BTS_BANK_CUR, ins_r.base} : {xbank, low_idx};
	wire [4:0] bus_raddr = rd_issue_dp ? dp_rf_idx : haddr[BTS_RF_BANK_BIT:2];
	wire [4:0] rf_raddr = (busy && (seq_rd || state_r == BTS_LDBASE)) ? seq_raddr : bus_raddr;

	wire ld_we = state_r == BTS_XFER && ins_r.load && !ab_any;
	wire bus_we = dp_wr && dp_rf;
	wire wa_en = ld_we || bus_we;
	wire [4:0] wa_addr = ld_we ? {xbank, cur_r} : dp_rf_idx;
	wire [31:0] wa_data = ld_we ? mem_rdata : hwdata;

	// Write-back in cycle two; after a load abort the base is put back
	wire wb_now = state_r == BTS_XFER && first_r && ins_r.wb;
	wire restore = seq_end && ins_r.load && abort_r;
	wire [31:0] restore_val = ins_r.wb ? newb_r : orig_base_r;
	wire wb_en = wb_now || restore;
	wire [31:0] wb_data = restore ? restore_val : newb_r;

	bts_regfile u_rf (
		.hclk(hclk),
		.hresetn(hresetn),
		.wa_en(wa_en),
		.wa_addr(wa_addr),
		.wa_data(wa_data),
		.wb_en(wb_en),
		.wb_addr({BTS_BANK_CUR, ins_r.base}),
		.wb_data(wb_data),
		.rd_addr(rf_raddr),
		.rd_data(rf_rdata)
	);

	bts_pick u_pick (
		.mask(rem_r),
		.low_idx(low_idx),
		.low_hot(low_hot),
		.count()
	);

	bts_pick u_cnt (
		.mask(ins_r.list),
		.low_idx(),
		.low_hot(),
		.count(list_cnt)
	);

	// ****************************************************
	// Address arithmetic
	// ****************************************************
	wire [31:0] span = {25'h0000000, list_cnt, 2'b00};
	wire [31:0] base_now = rf_rdata;
	wire [31:0] base_up = base_now + span;
	wire [31:0] base_dn = base_now - span;
	logic [31:0] low_addr;

	always_comb begin
		unique case ({ins_r.pre, ins_r.up})
			2'b01: low_addr = base_now;
			2'b11: low_addr = base_now + BTS_WORD_BYTES;
			2'b00: low_addr = base_dn + BTS_WORD_BYTES;
			2'b10: low_addr = base_dn;
		endcase
	end

	// ****************************************************
	// Sequencer
	// ****************************************************
	wire last_xfer = rem_r == 16'h0000;
	assign busy = state_r != BTS_IDLE;
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			BTS_IDLE: if (start) state_nxt = BTS_LDBASE;
			BTS_LDBASE: state_nxt = BTS_PREF;
			BTS_PREF: state_nxt = BTS_XFER;
			BTS_XFER: if (last_xfer) state_nxt = ins_r.load ? BTS_INT : BTS_END;
			BTS_INT: state_nxt = (ins_r.list[BTS_PC_IDX] && !abort_r) ? BTS_PCN : BTS_END;
			BTS_PCN: state_nxt = BTS_PCS;
			BTS_PCS: state_nxt = BTS_END;
			BTS_END: state_nxt = BTS_IDLE;
		endcase
	end

	always_comb begin
		cycles_nxt = cycles_r;
		if (start) begin
			cycles_nxt = 32'h00000000;
		end else if (mem_req.ctype != BTS_CYC_NONE) begin
			cycles_nxt = cycles_r + 32'h00000001;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= BTS_IDLE;
			cycles_r <= 32'h00000000;
		end else begin
			state_r <= state_nxt;
			cycles_r <= cycles_nxt;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ins_r <= '0;
			rem_r <= 16'h0000;
			cur_r <= 4'h0;
			addr_r <= 32'h00000000;
			orig_base_r <= 32'h00000000;
			newb_r <= 32'h00000000;
			first_r <= 1'b0;
			wbdone_r <= 1'b0;
			abort_r <= 1'b0;
		end else begin
			if (start) begin
				ins_r <= bts_decode(hwdata);
				rem_r <= bts_decode(hwdata).list;
				abort_r <= 1'b0;
				wbdone_r <= 1'b0;
			end
			if (state_r == BTS_PREF) begin
				orig_base_r <= base_now;
				newb_r <= ins_r.up ? base_up : base_dn;
				addr_r <= low_addr;
				first_r <= 1'b1;
			end
			if (seq_rd) begin
				cur_r <= low_idx;
				rem_r <= rem_r & ~low_hot;
			end
			if (state_r == BTS_XFER) begin
				addr_r <= addr_r + BTS_WORD_BYTES;
				first_r <= 1'b0;
				wbdone_r <= wbdone_r || wb_now;
				abort_r <= ab_any;
			end
		end
	end

	// ****************************************************
	// Memory request
	// ****************************************************
	wire base_fresh = wbdone_r && cur_r == ins_r.base && !xbank;
	logic [31:0] st_data;
	always_comb begin
		if (cur_r == BTS_PC_IDX) begin
			st_data = iaddr_r + BTS_PC_STORE_OFS;
		end else if (base_fresh) begin
			st_data = newb_r;
		end else begin
			st_data = rf_rdata;
		end
	end

	always_comb begin
		mem_req = '0;
		unique case (state_r)
			BTS_PREF, BTS_PCN: mem_req.ctype = BTS_CYC_N;
			BTS_PCS: mem_req.ctype = BTS_CYC_S;
			BTS_INT: mem_req.ctype = BTS_CYC_I;
			BTS_XFER: begin
				mem_req.active = 1'b1;
				mem_req.write = !ins_r.load;
				mem_req.addr = addr_r;
				mem_req.wdata = ins_r.load ? 32'h00000000 : st_data;
				mem_req.ctype = (first_r && !ins_r.load) ? BTS_CYC_N : BTS_CYC_S;
			end
			default: mem_req.ctype = BTS_CYC_NONE;
		endcase
	end

	assign data_abort_trap = set_abort;

	// ****************************************************
	// Read data mux
	// ****************************************************
	logic [31:0] csr_rdata;
	always_comb begin
		unique case (dp_addr_r)
			BTS_OFS_INSTR: csr_rdata = {7'h00, ins_r.pre, ins_r.up, ins_r.user, ins_r.wb,
				ins_r.load, ins_r.base, ins_r.list};
			BTS_OFS_IADDR: csr_rdata = iaddr_r;
			BTS_OFS_STATUS: csr_rdata = {29'h00000000, pcload_flag_r, abort_flag_r, busy};
			BTS_OFS_CUR_SW: csr_rdata = cur_sw_r;
			BTS_OFS_SAVED_SW: csr_rdata = saved_sw_r;
			BTS_OFS_CYCLES: csr_rdata = cycles_r;
			default: csr_rdata = 32'h00000000;
		endcase
	end

	assign hrdata = dp_rf ? rf_rdata : csr_rdata;
	logic [2:0] unused_size;
	assign unused_size = hsize;
endmodule

/* verification/bts_top_sva.sv */
`timescale 1ns/1ps
module bts_top_sva
	import bts_pkg::*;
(
	input wire logic hclk, // Clock
	input wire logic hresetn, // Reset, active low
	input wire logic hresp, // Bus response
	input wire bts_pkg::bts_mem_req_s mem_req, // Memory request
	input wire logic mem_abort, // Abort from memory manager
	input wire logic data_abort_trap // Trap pulse
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic seen_r;
	logic seen_nxt;
	// Remembers an abort until the trap of its instruction
	assign seen_nxt = data_abort_trap ? 1'b0 : (seen_r | (mem_req.active & mem_abort));
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) seen_r <= 1'b0;
		else seen_r <= seen_nxt;
	end
	property p_step;
		mem_req.active && mem_req.ctype == BTS_CYC_S && $past(mem_req.active)
		&& ($past(mem_req.ctype) == BTS_CYC_S || mem_req.write)
		|-> mem_req.addr == $past(mem_req.addr) + 32'h00000004;
	endproperty
	a_step: assert property (p_step) else $error("word address did not step up by 4");
	property p_store_first;
		$rose(mem_req.active && mem_req.write) |-> mem_req.ctype == BTS_CYC_N;
	endproperty
	a_store_first: assert property (p_store_first) else $error("first store not N");
	property p_store_seq;
		mem_req.active && mem_req.write && $past(mem_req.active && mem_req.write)
		|-> mem_req.ctype == BTS_CYC_S;
	endproperty
	a_store_seq: assert property (p_store_seq) else $error("later store not S");
	property p_load_int;
		mem_req.active && !mem_req.write && $past(mem_req.ctype) == BTS_CYC_S
		##1 !mem_req.active |-> mem_req.ctype == BTS_CYC_I;
	endproperty
	a_load_int: assert property (p_load_int) else $error("load not ended by I cycle");
	property p_trap_cause;
		data_abort_trap |-> seen_r;
	endproperty
	a_trap_cause: assert property (p_trap_cause) else $error("trap without abort");
	property p_trap_pulse;
		data_abort_trap |=> !data_abort_trap;
	endproperty
	a_trap_pulse: assert property (p_trap_pulse) else $error("trap longer than a cycle");
	property p_abort_trap;
		mem_req.active && mem_abort |-> ##[1:24] data_abort_trap;
	endproperty
	a_abort_trap: assert property (p_abort_trap) else $error("abort not trapped");
	property p_skip_pc;
		mem_req.ctype == BTS_CYC_I && seen_r |=> data_abort_trap && !mem_req.active;
	endproperty
	a_skip_pc: assert property (p_skip_pc) else $error("aborted load went on");
	property p_trap_idle;
		data_abort_trap |-> !mem_req.active && mem_req.ctype == BTS_CYC_NONE;
	endproperty
	a_trap_idle: assert property (p_trap_idle) else $error("trap before instruction end");
	property p_resp_okay;
		hresp == 1'b0;
	endproperty
	a_resp_okay: assert property (p_resp_okay) else $error("response not OKAY");
endmodule
bind bts_top bts_top_sva u_sva (.hclk(hclk), .hresetn(hresetn), .hresp(hresp),
	.mem_req(mem_req), .mem_abort(mem_abort), .data_abort_trap(data_abort_trap));

/* verification/bts_mem_model.sv */
`timescale 1ns/1ps
module bts_mem_model
	import bts_pkg::*;
(
	input wire logic hclk, // Clock
	input wire bts_pkg::bts_mem_req_s mem_req, // Request from the sequencer
	input wire logic [31:0] abort_addr, // Word to refuse, zero for none
	output logic [31:0] mem_rdata, // Load data
	output logic mem_abort // Abort flag
);
	logic [31:0] mem [0:4095];
	logic [31:0] last_r;
	wire load_sel = mem_req.active & ~mem_req.write;
	wire addr_bad = (abort_addr != 32'h0) & (mem_req.addr[31:2] == abort_addr[31:2]);
	assign mem_abort = mem_req.active & addr_bad;
	// Idle data toggles so a stray sample never looks valid
	assign mem_rdata = load_sel ? mem[mem_req.addr[13:2]] : ~last_r;
	always @(posedge hclk) begin
		last_r <= mem_rdata;
		if (mem_req.active & mem_req.write & ~mem_abort) mem[mem_req.addr[13:2]] <= mem_req.wdata;
	end
endmodule

/* verification/bts_top_tb.sv */
`timescale 1ns/1ps
module bts_top_tb;
	import bts_pkg::*;
	typedef struct packed {
		logic [31:0] ins;
		logic [31:0] low;
		logic [31:0] after;
		logic [31:0] cyc;
		logic [31:0] ab;
	} bts_row_s;
	// Base is always r2, never the program counter register, mask never empty
	localparam bts_row_s ROWS [0:12] = '{
		'{32'h00A200A2, 32'h00001000, 32'h0000100C, 32'h4, 32'h0},
		'{32'h01A200A2, 32'h00001004, 32'h0000100C, 32'h4, 32'h0},
		'{32'h002200A2, 32'h00000FF8, 32'h00000FF4, 32'h4, 32'h0},
		'{32'h010200A2, 32'h00000FF4, 32'h00001000, 32'h4, 32'h0},
		'{32'h00B200A2, 32'h00001000, 32'h0000100C, 32'h5, 32'h0},
		'{32'h013200A2, 32'h00000FF4, 32'h00000FF4, 32'h5, 32'h0},
		'{32'h00A28006, 32'h00001000, 32'h0000100C, 32'h4, 32'h0},
		'{32'h00A2000C, 32'h00001000, 32'h00001008, 32'h3, 32'h0},
		'{32'h00B20006, 32'h00001000, 32'h00001008, 32'h4, 32'h0},
		'{32'h00928001, 32'h00001000, 32'h00001000, 32'h6, 32'h0},
		'{32'h00A200A2, 32'h00001000, 32'h0000100C, 32'h4, 32'h00001004},
		'{32'h00B28006, 32'h00001000, 32'h0000100C, 32'h5, 32'h00001004},
		'{32'h0092000C, 32'h00001000, 32'h00001000, 32'h4, 32'h00001004}};
	logic hclk;
	logic hresetn;
	logic hsel;
	logic hwrite;
	logic hreadyout;
	logic hresp;
	logic mem_abort;
	logic data_abort_trap;
	logic hit;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic [31:0] mem_rdata;
	logic [31:0] abort_addr;
	logic [31:0] last_addr;
	logic [31:0] a;
	logic [31:0] ev;
	logic [31:0] ba;
	bts_mem_req_s mem_req;
	int miscompares;
	int checks;
	int trap_cnt;
	int k;
	bts_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .mem_req(mem_req), .mem_rdata(mem_rdata),
		.mem_abort(mem_abort), .data_abort_trap(data_abort_trap));
	bts_mem_model u_mem (.hclk(hclk), .mem_req(mem_req), .abort_addr(abort_addr),
		.mem_rdata(mem_rdata), .mem_abort(mem_abort));
	// ****************************************************
	// Tasks
	// ****************************************************
	task automatic print_verdict();
		if (miscompares == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic cmp32(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic xfer(input logic w, input logic [31:0] ad, input logic [31:0] wd,
		output logic [31:0] rd);
		int n;
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= ad;
		hwrite <= w;
		n = 0;
		do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 500);
		htrans <= 2'h0;
		hwdata <= wd;
		do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 500);
		rd = hrdata;
		if (n >= 500) begin miscompares++; print_verdict(); end
	endtask
	task automatic wr(input logic [31:0] ad, input logic [31:0] d);
		logic [31:0] x;
		xfer(1'b1, ad, d, x);
	endtask
	task automatic rd_cmp(input string nm, input logic [31:0] ad, input logic [31:0] e);
		logic [31:0] x;
		xfer(1'b0, ad, 32'h0, x);
		cmp32(nm, e, x);
	endtask
	function automatic logic [31:0] memval(input logic [31:0] ad);
		return 32'h5A000000 ^ ad;
	endfunction
	task automatic init_state();
		for (int i = 0; i < 4096; i++) u_mem.mem[i] = memval(32'(i * 4));
		for (int i = 0; i < 16; i++) wr(32'h80 + 32'(4 * i), 32'hA0000000 + 32'(i));
		wr(32'h88, 32'h00001000);
	endtask
	// ****************************************************
	// Clock, monitors and sequence
	// ****************************************************
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		if (data_abort_trap === 1'b1) trap_cnt++;
		if (mem_req.active === 1'b1) last_addr = mem_req.addr;
	end
	initial begin
		{hresetn, hsel, hwrite, htrans, haddr, hwdata, abort_addr} = '0;
		hsize = 3'h2;
		miscompares = 0;
		checks = 0;
		trap_cnt = 0;
		repeat (20) @(posedge hclk);
		cmp32("reset_outputs", 32'h4, {29'h0, hreadyout, hresp, data_abort_trap});
		cmp32("reset_mem_req", 32'h0, {31'h0, mem_req.active});
		hresetn <= 1'b1;
		@(posedge hclk);
		rd_cmp("status", 32'h08, 32'h0);
		rd_cmp("reg_reset", 32'h84, 32'h0);
		rd_cmp("unmapped", 32'h40, 32'h0);
		wr(32'h04, 32'h00002000);
		foreach (ROWS[r]) begin
			init_state();
			abort_addr <= ROWS[r].ab;
			trap_cnt = 0;
			wr(32'h00, ROWS[r].ins);
			xfer(1'b0, 32'h80, 32'h0, a);
			rd_cmp("cycles", 32'h14, ROWS[r].cyc);
			k = 0;
			hit = 1'b0;
			ba = 32'h0;
			for (int i = 0; i < 16; i++) begin
				if (ROWS[r].ins[i]) begin
					a = ROWS[r].low + 32'(4 * k);
					hit |= (a == ROWS[r].ab);
					if (i == 2) ba = a;
					if (!ROWS[r].ins[BTS_BIT_LOAD]) begin
						ev = (k == 0) ? 32'h00001000 : ROWS[r].after;
						if (i != 2) ev = (i == 15) ? 32'h0000200C : 32'hA0000000 + 32'(i);
						if (a == ROWS[r].ab) ev = memval(a);
						cmp32("stored_word", ev, u_mem.mem[a[13:2]]);
					end else if (i != 2) begin
						ev = hit ? 32'hA0000000 + 32'(i) : memval(a);
						rd_cmp("loaded_reg", 32'h80 + 32'(4 * i), ev);
					end
					k++;
				end
			end
			ev = ROWS[r].after;
			if (ROWS[r].ins[BTS_BIT_LOAD] && ROWS[r].ins[2] && ROWS[r].ab == 0) ev = memval(ba);
			rd_cmp("base_reg", 32'h88, ev);
			cmp32("trap_count", (ROWS[r].ab != 0) ? 32'h1 : 32'h0, 32'(trap_cnt));
		end
		abort_addr <= 32'h0;
		init_state();
		wr(32'h88, 32'h00001002);
		wr(32'h00, 32'h00820001);
		xfer(1'b0, 32'h80, 32'h0, a);
		cmp32("addr_low_bits", 32'h00001002, last_addr);
		wr(32'h88, 32'h00001000);
		// User-bit transfers without write-back
		wr(32'hC0, 32'hB0000000);
		wr(32'hC4, 32'hB0000001);
		wr(32'h00, 32'h00420003);
		xfer(1'b0, 32'h80, 32'h0, a);
		cmp32("user_store0", 32'hB0000000, u_mem.mem[12'h3FF]);
		cmp32("user_store1", 32'hB0000001, u_mem.mem[12'h400]);
		wr(32'h00, 32'h00520001);
		rd_cmp("user_load", 32'hC0, 32'hB0000001);
		rd_cmp("current_kept", 32'h80, 32'hA0000000);
		wr(32'h10, 32'h000000D3);
		wr(32'h0C, 32'h00000010);
		wr(32'h00, 32'h00D28000);
		rd_cmp("pc_loaded", 32'hBC, 32'hB0000001);
		rd_cmp("current_status_word", 32'h0C, 32'h000000D3);
		wr(32'hC0, 32'hB0000005);
		wr(32'h00, 32'h00428001);
		xfer(1'b0, 32'h80, 32'h0, a);
		cmp32("user_pc_store", 32'hB0000005, u_mem.mem[12'h3FF]);
		cmp32("user_pc_value", 32'h0000200C, u_mem.mem[12'h400]);
		rd_cmp("instr_readback", 32'h00, 32'h00428001);
		rd_cmp("status_sticky", 32'h08, 32'h00000006);
		wr(32'h08, 32'h00000006);
		rd_cmp("status_cleared", 32'h08, 32'h00000000);
		// Reset in the middle of an instruction
		wr(32'h00, 32'h00A200A2);
		@(posedge hclk);
		hresetn <= 1'b0;
		@(posedge hclk);
		cmp32("midrun_reset", 32'h4, {29'h0, hreadyout, hresp, data_abort_trap});
		cmp32("midrun_mem_req", 32'h0, {29'h0, mem_req.active, mem_req.ctype});
		hresetn <= 1'b1;
		@(posedge hclk);
		rd_cmp("reset_cycles", 32'h14, 32'h0);
		rd_cmp("reset_base", 32'h88, 32'h0);
		print_verdict();
	end
endmodule
